// ### rtl/cpu_opcode_tail_decode.v
`include "opcode_tail_regs.vh"

// Notes on behaviour
// RULE1: Trap advances pc, pushes pc low, pc high, index, acc, flags; sets mask.
// RULE2: Trap then loads pc high, pc low from vector; ten cycles, only mask changes.
// RULE3: Copy acc to index takes two cycles, flags unchanged.
// RULE4: Copy index to acc takes two cycles, flags unchanged.
// RULE5: Test byte sets only negative and zero, in five addressing forms.
// RULE6: Test byte cycles: short index 5, plain index 4, implied 3, page zero 4.
// RULE7: Wait halts the cpu clock, clears mask; two cycles, one byte.
// RULE8: Long address operands are high byte then low byte.
// RULE9: Long index offset is high then low byte added to index.
// RULE10: Short index offset is one unsigned byte added to index.
// RULE11: Bit-test-branch carries page-zero address then signed relative offset.
// RULE12: Trap vector address pair is fixed by core configuration parameters.
module cpu_opcode_tail_decode #(
  parameter [15:0] TRAP_VECTOR_HIGH_ADDR = 16'hfff0, // Plain default, set by the core.
  parameter [15:0] TRAP_VECTOR_LOW_ADDR = 16'hfff1   // Plain default, set by the core.
) (
  input wire clock_in,                 // Core clock.
  input wire rst_n_in,                 // Asynchronous reset, active low.
  input wire start_in,                 // Opcode fetched, begin execution.
  input wire [7:0] opcode_in,          // Opcode byte.
  input wire [15:0] pc_in,             // Address of the opcode.
  input wire [7:0] sp_in,              // Stack pointer.
  input wire [7:0] acc_in,             // Accumulator.
  input wire [7:0] index_in,           // Index register.
  input wire [7:0] flags_in,           // Flag register.
  input wire [7:0] mem_rdata_in,       // Read data, valid while the read strobe is high.
  input wire wake_in,                  // Interrupt request ending the halt.
  input wire [2:0] layout_mode_in,     // Operand layout mode for address forming.
  input wire [7:0] layout_first_in,    // First operand byte.
  input wire [7:0] layout_second_in,   // Second operand byte.
  input wire [15:0] layout_next_pc_in, // Address of the next instruction.
  output reg busy_out,                 // Instruction in progress or halted.
  output reg done_out,                 // One-cycle pulse, results valid.
  output reg unknown_out,              // Pulse with done for an opcode not handled here.
  output reg [15:0] pc_out,            // New program counter.
  output reg [7:0] sp_out,             // New stack pointer.
  output reg [7:0] acc_out,            // New accumulator.
  output reg [7:0] index_out,          // New index register.
  output reg [7:0] flags_out,          // New flag register.
  output reg [15:0] mem_addr_out,      // Memory address.
  output reg [7:0] mem_wdata_out,      // Memory write data.
  output reg mem_rd_out,               // Read strobe.
  output reg mem_wr_out,               // Write strobe.
  output reg clock_halt_out,           // Holds the cpu clock stopped.
  output reg [15:0] layout_addr_out,   // Registered effective address.
  output reg [15:0] layout_target_out  // Registered branch target.
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_EXEC = 3'b010;
  localparam [2:0] ST_HALT = 3'b100;

  reg [2:0] state;
  reg [3:0] step;
  reg [3:0] last_step;
  reg [7:0] op;
  reg [7:0] operand;
  reg [7:0] test_value;
  reg [7:0] vec_high;
  reg [2:0] ea_mode;
  wire [15:0] ea;
  wire [15:0] layout_addr;
  wire [15:0] layout_target;

  // Total cycles for each opcode; anything else finishes at once.
  function [3:0] cycles_of;
    input [7:0] code;
    begin
      case (code)
        `OP_SOFTWARE_TRAP: cycles_of = `CYC_TRAP;
        `OP_COPY_ACC_TO_INDEX: cycles_of = `CYC_COPY;
        `OP_COPY_INDEX_TO_ACC: cycles_of = `CYC_COPY;
        `OP_TEST_PAGE_ZERO: cycles_of = `CYC_TEST_PAGE_ZERO;
        `OP_TEST_ACC: cycles_of = `CYC_TEST_IMPLIED;
        `OP_TEST_INDEX: cycles_of = `CYC_TEST_IMPLIED;
        `OP_TEST_INDEX_SHORT: cycles_of = `CYC_TEST_INDEX_SHORT;
        `OP_TEST_INDEX_PLAIN: cycles_of = `CYC_TEST_INDEX_PLAIN;
        `OP_WAIT: cycles_of = `CYC_WAIT;
        default: cycles_of = `CYC_UNKNOWN;
      endcase
    end
  endfunction

  // Negative and zero from a byte; the other flags pass through.
  function [7:0] test_flags;
    input [7:0] flags;
    input [7:0] value;
    reg [7:0] f;
    begin
      f = flags;
      f[`FLAG_N] = value[7];
      f[`FLAG_Z] = (value == 8'h00);
      test_flags = f;
    end
  endfunction

  // Operand address for the memory forms of test byte.
  always @*
  begin
    case (op)
      `OP_TEST_PAGE_ZERO: ea_mode = `MODE_PAGE_ZERO;
      `OP_TEST_INDEX_SHORT: ea_mode = `MODE_INDEX_SHORT;
      default: ea_mode = `MODE_INDEX_PLAIN;
    endcase
  end

  operand_addr_former u_test_addr (
    .mode_in(ea_mode),
    .first_byte_in(operand),
    .second_byte_in(8'h00),
    .index_in(index_out),
    .next_pc_in(pc_out),
    .addr_out(ea),
    .target_out()
  );

  // Shared address former for the rest of the core, kept off the sequencer.
  operand_addr_former u_layout_addr (
    .mode_in(layout_mode_in),
    .first_byte_in(layout_first_in),
    .second_byte_in(layout_second_in),
    .index_in(index_in),
    .next_pc_in(layout_next_pc_in),
    .addr_out(layout_addr),
    .target_out(layout_target)
  );

  // Registered so every output comes from a flip-flop; one cycle of latency.
  always @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      layout_addr_out <= 16'h0000;
      layout_target_out <= 16'h0000;
    end
    else
    begin
      layout_addr_out <= layout_addr;
      layout_target_out <= layout_target;
    end
  end

  // Sequencer: one step per clock, results published on the last step.
  always @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state <= ST_IDLE;
      step <= 4'd0;
      last_step <= 4'd0;
      op <= 8'h00;
      operand <= 8'h00;
      test_value <= 8'h00;
      vec_high <= 8'h00;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      unknown_out <= 1'b0;
      pc_out <= `RST_PC;
      sp_out <= `RST_SP;
      acc_out <= `RST_ACC;
      index_out <= `RST_INDEX;
      flags_out <= `RST_FLAGS;
      mem_addr_out <= 16'h0000;
      mem_wdata_out <= 8'h00;
      mem_rd_out <= 1'b0;
      mem_wr_out <= 1'b0;
      clock_halt_out <= 1'b0;
    end
    else
    begin
      done_out <= 1'b0;
      unknown_out <= 1'b0;
      mem_rd_out <= 1'b0;
      mem_wr_out <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (start_in)
          begin
            // Working copies; a new opcode is ignored while busy.
            op <= opcode_in;
            pc_out <= pc_in;
            sp_out <= sp_in;
            acc_out <= acc_in;
            index_out <= index_in;
            flags_out <= flags_in;
            step <= 4'd0;
            last_step <= cycles_of(opcode_in) - 4'd1;
            busy_out <= 1'b1;
            state <= ST_EXEC;
          end
        end
        ST_EXEC:
        begin
          step <= step + 4'd1;
          case (op)
            `OP_SOFTWARE_TRAP:
            begin
              // RULE1: push order and decrement
              case (step)
                4'd0:
                begin
                  mem_addr_out <= {`STACK_PAGE, sp_out};
                  mem_wdata_out <= pc_out[7:0] + 8'h01;
                  mem_wr_out <= 1'b1;
                  pc_out <= pc_out + 16'h0001;
                  sp_out <= sp_out - 8'h01;
                end
                4'd1:
                begin
                  mem_addr_out <= {`STACK_PAGE, sp_out};
                  mem_wdata_out <= pc_out[15:8];
                  mem_wr_out <= 1'b1;
                  sp_out <= sp_out - 8'h01;
                end
                4'd2:
                begin
                  mem_addr_out <= {`STACK_PAGE, sp_out};
                  mem_wdata_out <= index_out;
                  mem_wr_out <= 1'b1;
                  sp_out <= sp_out - 8'h01;
                end
                4'd3:
                begin
                  mem_addr_out <= {`STACK_PAGE, sp_out};
                  mem_wdata_out <= acc_out;
                  mem_wr_out <= 1'b1;
                  sp_out <= sp_out - 8'h01;
                end
                4'd4:
                begin
                  // The flags go out before the mask is set.
                  mem_addr_out <= {`STACK_PAGE, sp_out};
                  mem_wdata_out <= flags_out;
                  mem_wr_out <= 1'b1;
                  sp_out <= sp_out - 8'h01;
                  flags_out[`FLAG_I] <= 1'b1;
                end
                4'd5:
                begin
                  // RULE12: fixed vector pair
                  mem_addr_out <= TRAP_VECTOR_HIGH_ADDR;
                  mem_rd_out <= 1'b1;
                end
                4'd6:
                begin
                  // RULE2: high byte first
                  vec_high <= mem_rdata_in;
                  mem_addr_out <= TRAP_VECTOR_LOW_ADDR;
                  mem_rd_out <= 1'b1;
                end
                4'd7: pc_out <= {vec_high, mem_rdata_in};
                default: ;
              endcase
            end
            `OP_COPY_ACC_TO_INDEX:
            begin
              // RULE3: acc into index
              if (step == last_step)
                index_out <= acc_out;
            end
            `OP_COPY_INDEX_TO_ACC:
            begin
              // RULE4: index into acc
              if (step == last_step)
                acc_out <= index_out;
            end
            `OP_TEST_ACC, `OP_TEST_INDEX:
            begin
              // RULE5: implied forms
              if (step == 4'd0)
                test_value <= (op == `OP_TEST_ACC) ? acc_out : index_out;
            end
            `OP_TEST_PAGE_ZERO, `OP_TEST_INDEX_SHORT, `OP_TEST_INDEX_PLAIN:
            begin
              // RULE6: fetch operand byte if any, then the memory byte
              if (step == 4'd0 && op != `OP_TEST_INDEX_PLAIN)
              begin
                mem_addr_out <= pc_out + 16'h0001;
                mem_rd_out <= 1'b1;
              end
              else if (step == 4'd0 || (step == 4'd1 && op == `OP_TEST_PAGE_ZERO)
                       || (step == 4'd2 && op == `OP_TEST_INDEX_SHORT))
              begin
                mem_addr_out <= (op == `OP_TEST_PAGE_ZERO) ?
                                {`ZERO_PAGE, mem_rdata_in} : ea;
                mem_rd_out <= 1'b1;
              end
              else if (step == 4'd1 && op == `OP_TEST_INDEX_SHORT)
                operand <= mem_rdata_in;
              else if (mem_rd_out)
                test_value <= mem_rdata_in;
            end
            default: ;
          endcase
          if (step == last_step)
          begin
            done_out <= 1'b1;
            unknown_out <= (cycles_of(op) == `CYC_UNKNOWN);
            busy_out <= 1'b0;
            state <= ST_IDLE;
            case (op)
              `OP_TEST_PAGE_ZERO, `OP_TEST_INDEX_SHORT:
              begin
                // RULE5: only negative and zero
                flags_out <= test_flags(flags_out, test_value);
                pc_out <= pc_out + 16'h0002;
              end
              `OP_TEST_ACC, `OP_TEST_INDEX, `OP_TEST_INDEX_PLAIN:
              begin
                flags_out <= test_flags(flags_out, test_value);
                pc_out <= pc_out + 16'h0001;
              end
              `OP_COPY_ACC_TO_INDEX, `OP_COPY_INDEX_TO_ACC:
                pc_out <= pc_out + 16'h0001;
              `OP_WAIT:
              begin
                // RULE7: clear mask, stop clock
                flags_out[`FLAG_I] <= 1'b0;
                pc_out <= pc_out + 16'h0001;
                clock_halt_out <= 1'b1;
                busy_out <= 1'b1;
                state <= ST_HALT;
              end
              `OP_SOFTWARE_TRAP: ;
              default: pc_out <= pc_out;
            endcase
          end
        end
        ST_HALT:
        begin
          // An interrupt request restarts the clock; the core then services it.
          if (wake_in)
          begin
            clock_halt_out <= 1'b0;
            busy_out <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule

// ### rtl/opcode_tail_regs.vh
`ifndef OPCODE_TAIL_REGS_VH
`define OPCODE_TAIL_REGS_VH

// Opcodes handled by this decoder.
`define OP_SOFTWARE_TRAP 8'h83
`define OP_COPY_ACC_TO_INDEX 8'h97
`define OP_COPY_INDEX_TO_ACC 8'h9f
`define OP_TEST_PAGE_ZERO 8'h3d
`define OP_TEST_ACC 8'h4d
`define OP_TEST_INDEX 8'h5d
`define OP_TEST_INDEX_SHORT 8'h6d
`define OP_TEST_INDEX_PLAIN 8'h7d
`define OP_WAIT 8'h8f

// Bit positions inside the flag register.
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_I 3
`define FLAG_H 4

// Reset values of the programmer-visible state.
`define RST_PC 16'h0000
`define RST_SP 8'hff
`define RST_ACC 8'h00
`define RST_INDEX 8'h00
`define RST_FLAGS 8'he8
`define STACK_PAGE 8'h00
`define ZERO_PAGE 8'h00

// Total cycles per instruction, the opcode fetch included.
`define CYC_TRAP 4'd10
`define CYC_COPY 4'd2
`define CYC_TEST_PAGE_ZERO 4'd4
`define CYC_TEST_IMPLIED 4'd3
`define CYC_TEST_INDEX_SHORT 4'd5
`define CYC_TEST_INDEX_PLAIN 4'd4
`define CYC_WAIT 4'd2
`define CYC_UNKNOWN 4'd1

// Operand layout modes.
`define MODE_PAGE_ZERO 3'd0
`define MODE_LONG_ADDRESS 3'd1
`define MODE_INDEX_LONG 3'd2
`define MODE_INDEX_SHORT 3'd3
`define MODE_INDEX_PLAIN 3'd4
`define MODE_BIT_BRANCH 3'd5

`endif

// ### rtl/operand_addr_former.v
`include "opcode_tail_regs.vh"

module operand_addr_former (
  input wire [2:0] mode_in,        // Operand layout mode.
  input wire [7:0] first_byte_in,  // First operand byte after the opcode.
  input wire [7:0] second_byte_in, // Second operand byte, if any.
  input wire [7:0] index_in,       // Index register.
  input wire [15:0] next_pc_in,    // Address of the following instruction.
  output reg [15:0] addr_out,      // Effective operand address.
  output reg [15:0] target_out     // Branch target for bit-test-and-branch.
);

  // The address is pure combinational; the caller registers it.
  always @*
  begin
    target_out = next_pc_in;
    case (mode_in)
      `MODE_PAGE_ZERO: addr_out = {`ZERO_PAGE, first_byte_in};
      // RULE8: high then low
      `MODE_LONG_ADDRESS: addr_out = {first_byte_in, second_byte_in};
      // RULE9: long offset sum
      `MODE_INDEX_LONG: addr_out = {first_byte_in, second_byte_in} + {8'h00, index_in};
      // RULE10: unsigned short offset
      `MODE_INDEX_SHORT: addr_out = {8'h00, first_byte_in} + {8'h00, index_in};
      `MODE_INDEX_PLAIN: addr_out = {8'h00, index_in};
      `MODE_BIT_BRANCH:
      begin
        // RULE11: address then offset
        addr_out = {`ZERO_PAGE, first_byte_in};
        target_out = next_pc_in + {{8{second_byte_in[7]}}, second_byte_in};
      end
      default: addr_out = 16'h0000;
    endcase
  end

endmodule

// ### verif/opcode_tail_sva.sv
`include "opcode_tail_regs.vh"

// Timing and value checks at the decoder's ports.
module opcode_tail_sva #(
  parameter [15:0] TRAP_VECTOR_HIGH_ADDR = 16'hfff0,
  parameter [15:0] TRAP_VECTOR_LOW_ADDR = 16'hfff1
) (
  input wire clock_in,
  input wire rst_n_in,
  input wire start_in,
  input wire [7:0] opcode_in,
  input wire [15:0] pc_in,
  input wire [7:0] sp_in,
  input wire [7:0] acc_in,
  input wire [7:0] index_in,
  input wire [7:0] flags_in,
  input wire [2:0] layout_mode_in,
  input wire [7:0] layout_first_in,
  input wire [7:0] layout_second_in,
  input wire busy_out,
  input wire done_out,
  input wire [7:0] sp_out,
  input wire [7:0] acc_out,
  input wire [7:0] index_out,
  input wire [7:0] flags_out,
  input wire [15:0] mem_addr_out,
  input wire [7:0] mem_wdata_out,
  input wire mem_rd_out,
  input wire mem_wr_out,
  input wire clock_halt_out,
  input wire [15:0] layout_addr_out
);
  timeunit 1ns;
  timeprecision 1ps;
  wire go;

  // A start only counts while the sequencer is idle.
  assign go = start_in && !busy_out;

  default clocking @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);

  // The start edge only enters the sequencer; step k shows at the sample k+2 edges later.
  AST_TRAP_PUSH: assert property (go && opcode_in == `OP_SOFTWARE_TRAP |-> ##2 mem_wr_out
    && mem_addr_out == {8'h00, $past(sp_in, 2)}
    && mem_wdata_out == $past(pc_in[7:0], 2) + 8'h01)
    else $error("trap first push wrong");
  AST_TRAP_MASK: assert property (go && opcode_in == `OP_SOFTWARE_TRAP |-> ##6 flags_out[3]
    && mem_wr_out && mem_wdata_out == $past(flags_in, 6)) else $error("trap flag push wrong");
  AST_TRAP_VECTOR: assert property (go && opcode_in == `OP_SOFTWARE_TRAP |-> ##7
    mem_rd_out && mem_addr_out == TRAP_VECTOR_HIGH_ADDR ##1
    mem_rd_out && mem_addr_out == TRAP_VECTOR_LOW_ADDR) else $error("trap vector read wrong");
  AST_TRAP_TIME: assert property (go && opcode_in == `OP_SOFTWARE_TRAP |=> !done_out[*8]
    ##1 !done_out ##1 !done_out ##1 done_out && flags_out == ($past(flags_in, 11) | 8'h08)
    && sp_out == $past(sp_in, 11) - 8'h05) else $error("trap end wrong");
  AST_ACC_TO_INDEX: assert property (go && opcode_in == `OP_COPY_ACC_TO_INDEX |=> !done_out
    ##1 !done_out ##1 done_out && index_out == $past(acc_in, 3)
    && flags_out == $past(flags_in, 3)) else $error("acc to index wrong");
  AST_INDEX_TO_ACC: assert property (go && opcode_in == `OP_COPY_INDEX_TO_ACC |=> !done_out
    ##1 !done_out ##1 done_out && acc_out == $past(index_in, 3)
    && flags_out == $past(flags_in, 3)) else $error("index to acc wrong");
  AST_TEST_ACC: assert property (go && opcode_in == `OP_TEST_ACC |-> ##4 done_out
    && flags_out[2] == $past(acc_in[7], 4) && flags_out[1] == ($past(acc_in, 4) == 8'h00)
    && (flags_out & 8'hf9) == ($past(flags_in, 4) & 8'hf9)) else $error("test acc wrong");
  AST_TEST_SHORT: assert property (go && opcode_in == `OP_TEST_INDEX_SHORT |=>
    !done_out[*5] ##1 done_out) else $error("test short index time wrong");
  AST_WAIT: assert property (go && opcode_in == `OP_WAIT |=> !done_out ##1 !done_out
    ##1 done_out && clock_halt_out && busy_out && !flags_out[3]) else $error("wait wrong");
  AST_LONG_ADDR: assert property (layout_mode_in == 3'd1 |=>
    layout_addr_out == {$past(layout_first_in), $past(layout_second_in)})
    else $error("long address wrong");
  AST_SHORT_INDEX: assert property (layout_mode_in == 3'd3 |=>
    layout_addr_out == {8'h00, $past(layout_first_in)} + {8'h00, $past(index_in)})
    else $error("short index address wrong");

  COV_TRAP: cover property (go && opcode_in == `OP_SOFTWARE_TRAP ##11 done_out);
  COV_HALT: cover property ($rose(clock_halt_out));
  COV_SHORT: cover property (go && opcode_in == `OP_TEST_INDEX_SHORT ##6 done_out);
endmodule

bind cpu_opcode_tail_decode opcode_tail_sva #(
  .TRAP_VECTOR_HIGH_ADDR(TRAP_VECTOR_HIGH_ADDR),
  .TRAP_VECTOR_LOW_ADDR(TRAP_VECTOR_LOW_ADDR)
) u_sva (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .start_in(start_in), .opcode_in(opcode_in),
  .pc_in(pc_in), .sp_in(sp_in), .acc_in(acc_in), .index_in(index_in), .flags_in(flags_in),
  .layout_mode_in(layout_mode_in), .layout_first_in(layout_first_in),
  .layout_second_in(layout_second_in), .busy_out(busy_out), .done_out(done_out),
  .sp_out(sp_out), .acc_out(acc_out), .index_out(index_out), .flags_out(flags_out),
  .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out), .mem_rd_out(mem_rd_out),
  .mem_wr_out(mem_wr_out), .clock_halt_out(clock_halt_out), .layout_addr_out(layout_addr_out)
);

// ### verif/mem_model.sv
// Program and data memory with a combinational read port.
module mem_model (
  input wire clock_in,       // Core clock.
  input wire rd_in,          // Read strobe.
  input wire wr_in,          // Write strobe.
  input wire [15:0] addr_in, // Byte address.
  input wire [7:0] wdata_in, // Write data.
  output wire [7:0] rdata_out // Read data.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  logic [7:0] last = 8'h00;

  // Outside a read the bus shows the inverse of the last byte, so stale data never matches.
  assign rdata_out = rd_in ? mem[addr_in] : ~last;

  // Writes land at the edge; the last read byte is kept for the idle pattern.
  always @(posedge clock_in)
  begin
    if (wr_in)
      mem[addr_in] <= wdata_in;
    if (rd_in)
      last <= mem[addr_in];
  end
endmodule

// ### verif/cpu_opcode_tail_decode_bench.sv
`include "opcode_tail_regs.vh"

// Directed bench for the opcode tail decoder.
module cpu_opcode_tail_decode_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in, rst_n_in = 1'b0, start_in = 1'b0, wake_in = 1'b0;
  logic [7:0] opcode_in = 8'h00, sp_in = 8'hff, acc_in = 8'h00, index_in = 8'h00;
  logic [7:0] flags_in = 8'he8, layout_first_in = 8'h00, layout_second_in = 8'h00;
  logic [15:0] pc_in = 16'h0000, layout_next_pc_in = 16'h0000;
  logic [2:0] layout_mode_in = 3'd0;
  wire busy_out, done_out, unknown_out, mem_rd_out, mem_wr_out, clock_halt_out;
  wire [7:0] sp_out, acc_out, index_out, flags_out, mem_wdata_out, mem_rdata_in;
  wire [15:0] pc_out, mem_addr_out, layout_addr_out, layout_target_out;
  int bad_count = 0;
  int n_tests = 0;

  cpu_opcode_tail_decode u_dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .start_in(start_in),
    .opcode_in(opcode_in), .pc_in(pc_in), .sp_in(sp_in), .acc_in(acc_in), .index_in(index_in),
    .flags_in(flags_in), .mem_rdata_in(mem_rdata_in), .wake_in(wake_in),
    .layout_mode_in(layout_mode_in), .layout_first_in(layout_first_in),
    .layout_second_in(layout_second_in), .layout_next_pc_in(layout_next_pc_in),
    .busy_out(busy_out), .done_out(done_out), .unknown_out(unknown_out), .pc_out(pc_out),
    .sp_out(sp_out), .acc_out(acc_out), .index_out(index_out), .flags_out(flags_out),
    .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out), .mem_rd_out(mem_rd_out),
    .mem_wr_out(mem_wr_out), .clock_halt_out(clock_halt_out),
    .layout_addr_out(layout_addr_out), .layout_target_out(layout_target_out));
  mem_model u_mem (.clock_in(clock_in), .rd_in(mem_rd_out), .wr_in(mem_wr_out),
    .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .rdata_out(mem_rdata_in));

  // Free-running core clock.
  initial
  begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end

  // Prints the verdict and ends the run.
  task give_verdict();
    if (bad_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Byte and word comparisons.
  task check8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task check16(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Starts one instruction, then counts cycles to done under a bound.
  task run(input logic [7:0] op, input logic [15:0] pc, input logic [7:0] sp, a, x, f,
    input logic [15:0] ncyc);
    logic [15:0] n;
    @(posedge clock_in);
    start_in <= 1'b1;
    opcode_in <= op;
    pc_in <= pc;
    sp_in <= sp;
    acc_in <= a;
    index_in <= x;
    flags_in <= f;
    @(posedge clock_in);
    start_in <= 1'b0;
    n = 16'h0000;
    forever
    begin
      @(negedge clock_in);
      if (done_out === 1'b1)
        break;
      n++;
      if (n > 16'h0028)
      begin
        bad_count++;
        give_verdict();
      end
    end
    check16(n, ncyc);
  endtask

  task s_trap();
    logic [7:0] st [5] = '{8'h00, 8'h13, 8'ha5, 8'h5a, 8'he0};
    u_mem.mem[16'hfff0] = 8'hab;
    u_mem.mem[16'hfff1] = 8'hcd;
    run(`OP_SOFTWARE_TRAP, 16'h12ff, 8'h80, 8'h5a, 8'ha5, 8'he0, 16'h000a);
    check16(pc_out, 16'habcd);
    check8(flags_out, 8'he8);
    check8(sp_out, 8'h7b);
    for (int i = 0; i < 5; i++)
      check8(u_mem.mem[16'h0080 - i], st[i]);
  endtask

  task s_copy();
    run(`OP_COPY_ACC_TO_INDEX, 16'h0200, 8'hff, 8'h3c, 8'h11, 8'hff, 16'h0002);
    check8(index_out, 8'h3c);
    check8(flags_out, 8'hff);
    check8({7'h00, unknown_out}, 8'h00);
    run(`OP_COPY_INDEX_TO_ACC, 16'h0201, 8'hff, 8'h11, 8'hc3, 8'h00, 16'h0002);
    check8(acc_out, 8'hc3);
    check8(flags_out, 8'h00);
    check16(pc_out, 16'h0202);
  endtask

  // Each addressing form with zero, negative and positive operands.
  task s_test();
    logic [7:0] ops [5] = '{8'h3d, 8'h4d, 8'h5d, 8'h6d, 8'h7d};
    logic [15:0] cyc [5] = '{16'h0004, 16'h0003, 16'h0003, 16'h0005, 16'h0004};
    logic [7:0] vals [3] = '{8'h00, 8'h80, 8'h7f};
    logic [7:0] v;
    for (int i = 0; i < 3; i++)
      for (int k = 0; k < 5; k++)
      begin
        v = vals[i];
        u_mem.mem[16'h0301] = (k == 0) ? 8'h40 : 8'h20;
        u_mem.mem[16'h0040] = v;
        u_mem.mem[16'h0110] = v;
        u_mem.mem[16'h00f0] = v;
        run(ops[k], 16'h0300, 8'hff, (k == 1) ? v : ~v, (k == 2) ? v : 8'hf0, 8'h1b,
          cyc[k]);
        check8(flags_out, 8'h19 | {5'h00, v[7], v == 8'h00, 1'b0});
        check16(pc_out, (k == 0 || k == 3) ? 16'h0302 : 16'h0301);
      end
  endtask

  task s_wait();
    run(`OP_WAIT, 16'h0400, 8'hff, 8'h00, 8'h00, 8'he8, 16'h0002);
    check8(flags_out, 8'he0);
    check16(pc_out, 16'h0401);
    repeat (3) @(negedge clock_in);
    check8({6'h00, clock_halt_out, busy_out}, 8'h03);
    @(posedge clock_in);
    wake_in <= 1'b1;
    @(posedge clock_in);
    wake_in <= 1'b0;
    @(negedge clock_in);
    check8({6'h00, clock_halt_out, busy_out}, 8'h00);
  endtask

  // Every operand layout, with a high offset bit to expose sign extension.
  task s_layout();
    logic [15:0] la [6] = '{16'h00c8, 16'hc8fe, 16'hc92e, 16'h00f8, 16'h0030, 16'h00c8};
    for (int m = 0; m < 6; m++)
    begin
      @(posedge clock_in);
      layout_mode_in <= 3'(m);
      layout_first_in <= 8'hc8;
      layout_second_in <= 8'hfe;
      layout_next_pc_in <= 16'h2000;
      index_in <= 8'h30;
      @(posedge clock_in);
      @(negedge clock_in);
      check16(layout_addr_out, la[m]);
    end
    check16(layout_target_out, 16'h1ffe);
  endtask

  // Main sequence.
  initial
  begin
    repeat (5) @(posedge clock_in);
    rst_n_in <= 1'b1;
    s_trap();
    s_copy();
    s_test();
    s_wait();
    s_layout();
    give_verdict();
  end
endmodule
